// ==== pmim_checker.sv ====
// assertion checker for the interrupt mapping block
`timescale 1ns/100ps
`default_nettype none
module pmim_checker
(
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       irq_line_a,
	input wire logic       irq_line_b,
	input wire logic       tx_ready,
	input wire logic       line_a_tx_source_sel,
	input wire logic       line_b_tx_source_sel,
	input wire logic       queue_empty_evt,
	input wire logic       queue_full_evt,
	input wire logic       queue_level_evt,
	input wire logic       send_complete_evt,
	input wire logic       sync_seen,
	input wire logic       addr_seen,
	input wire logic       payload_ready_evt,
	input wire logic       addr_match_evt,
	input wire logic       tx_start,
	input wire logic       queue_flush,
	input wire logic [1:0] line_a_rx_source_sel,
	input wire logic [1:0] line_b_rx_source_sel,
	input wire logic [1:0] addr_filter_mode,
	input wire logic [2:0] chip_operating_mode
);
	// ========
	// mode decode and selected transmit sources
	wire logic rx = chip_operating_mode == pmim_pkg::MODE_RX;
	wire logic sb = chip_operating_mode == pmim_pkg::MODE_STANDBY;
	wire logic tx = chip_operating_mode == pmim_pkg::MODE_TX;
	wire logic a_src = line_a_tx_source_sel ? queue_empty_evt : queue_level_evt;
	wire logic b_src = line_b_tx_source_sel ? send_complete_evt : queue_full_evt;
	wire logic go = tx && line_a_tx_source_sel && tx_ready && !queue_empty_evt;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	a_rx_empty_a:
		assert property (rx && line_a_rx_source_sel == 2'h2 |=> irq_line_a == $past(queue_empty_evt))
		else $error("line a rx empty");
	b_full_a:
		assert property ((rx || sb) && line_b_rx_source_sel == 2'h1 |=>
			irq_line_b == $past(queue_full_evt)) else $error("line b full");
	a_tx_src_a:
		assert property (tx |=> irq_line_a == $past(a_src)) else $error("line a tx");
	b_tx_src_a:
		assert property (tx |=> irq_line_b == $past(b_src)) else $error("line b tx");
	match_gate_a:
		assert property ($rose(addr_match_evt) |-> $past(sync_seen)
			|| ($past(addr_seen) && $past(addr_filter_mode) != 2'h0))
		else $error("match without filter");
	auto_start_a:
		assert property (1'b1 |=> tx_start == $past(go)) else $error("tx start");
	ready_hold_a:
		assert property (payload_ready_evt && !queue_empty_evt |=> payload_ready_evt)
		else $error("ready dropped");
	tx_flush_a:
		assert property (tx && line_a_tx_source_sel && send_complete_evt |-> ##1 queue_flush)
		else $error("no flush");
endmodule // pmim_checker
bind pmim_top pmim_checker chk_u (.*);
`default_nettype wire

// ==== pmim_host.sv ====
// behavioural host that sequences chip modes around send and receive
`timescale 1ns/100ps
`default_nettype none
module pmim_host #(parameter int BIT_CYC = 4)
(
	input  wire logic       core_clk,
	input  wire logic [2:0] want_mode,
	input  wire logic [1:0] seq_cmd,
	input  wire logic       irq_line_a,
	input  wire logic       irq_line_b,
	output logic      [2:0] mode,
	output logic            rd_strobe,
	output logic            busy
);
	// ========
	// states: 1 load, 2 listen, 3 send, 4 settle, 5 unload
	int st = 0;
	int n = 0;
	assign busy = st != 0;
	assign mode = !busy ? want_mode : st == 2 ? pmim_pkg::MODE_RX :
		st == 3 || st == 4 ? pmim_pkg::MODE_TX : pmim_pkg::MODE_STANDBY;
	always @(posedge core_clk)
	begin
		n <= (st == 0 || st == 3) ? 0 : n + 1;
		rd_strobe <= st == 5 && !irq_line_a;
		case (st)
			0: st <= seq_cmd;
			1: if (n > 4) st <= 3;
			2: if (irq_line_b) st <= 5;
			3: if (irq_line_b) st <= 4;
			4: if (n == BIT_CYC) st <= 0;
			default: if (irq_line_a) st <= 0;
		endcase
	end
endmodule // pmim_host
`default_nettype wire

// ==== pmim_pkg.sv ====
// package of constants for the packet mode interrupt mapping block
`default_nettype none
package pmim_pkg;
	// chip operating mode codes
	localparam logic [2:0] MODE_SLEEP   = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	localparam logic [2:0] MODE_SYNTH   = 3'h2;
	localparam logic [2:0] MODE_RX      = 3'h3;
	localparam logic [2:0] MODE_TX      = 3'h4;
	// line a rx selector codes
	localparam logic [1:0] A_RX_READY  = 2'h0;
	localparam logic [1:0] A_RX_WRBYTE = 2'h1;
	localparam logic [1:0] A_RX_EMPTY  = 2'h2;
	localparam logic [1:0] A_RX_MATCH  = 2'h3;
	// line b rx selector codes
	localparam logic [1:0] B_RX_PASS   = 2'h0;
	localparam logic [1:0] B_RX_FULL   = 2'h1;
	localparam logic [1:0] B_RX_RSSI   = 2'h2;
	localparam logic [1:0] B_RX_LEVEL  = 2'h3;
	// address filter off code
	localparam logic [1:0] ADDR_FILT_OFF = 2'h0;
	// reset values
	localparam logic       IRQ_RST     = 1'b0;
	localparam logic       FLAG_RST    = 1'b0;
endpackage : pmim_pkg
`default_nettype wire

// ==== pmim_sel.sv ====
// source selector for both interrupt lines
`timescale 1ns/100ps
`default_nettype none
module pmim_sel
(
	input  wire logic [2:0] mode,
	input  wire logic [1:0] a_rx_sel,
	input  wire logic [1:0] b_rx_sel,
	input  wire logic       a_tx_sel,
	input  wire logic       b_tx_sel,
	input  wire logic       ready_ev,
	input  wire logic       wrbyte_ev,
	input  wire logic       empty_ev,
	input  wire logic       match_ev,
	input  wire logic       full_ev,
	input  wire logic       pass_ev,
	input  wire logic       rssi_ev,
	input  wire logic       level_ev,
	input  wire logic       done_ev,
	output logic            line_a,
	output logic            line_b
);
	always_comb
	begin
		line_a = 1'b0;
		line_b = 1'b0;
		if (mode == pmim_pkg::MODE_RX)
		begin
			unique case (a_rx_sel)
				pmim_pkg::A_RX_READY:  line_a = ready_ev;
				pmim_pkg::A_RX_WRBYTE: line_a = wrbyte_ev;
				pmim_pkg::A_RX_EMPTY:  line_a = empty_ev;
				pmim_pkg::A_RX_MATCH:  line_a = match_ev;
			endcase
			unique case (b_rx_sel)
				pmim_pkg::B_RX_PASS:  line_b = pass_ev;
				pmim_pkg::B_RX_FULL:  line_b = full_ev;
				pmim_pkg::B_RX_RSSI:  line_b = rssi_ev;
				pmim_pkg::B_RX_LEVEL: line_b = level_ev;
			endcase
		end
		else if (mode == pmim_pkg::MODE_STANDBY)
		begin
			line_a = (a_rx_sel == pmim_pkg::A_RX_EMPTY) & empty_ev;
			line_b = ((b_rx_sel == pmim_pkg::B_RX_FULL) & full_ev)
				| ((b_rx_sel == pmim_pkg::B_RX_LEVEL) & level_ev);
		end
		else if (mode == pmim_pkg::MODE_TX)
		begin
			line_a = a_tx_sel ? empty_ev : level_ev;
			line_b = b_tx_sel ? done_ev : full_ev;
		end
	end
endmodule // pmim_sel
`default_nettype wire

// ==== pmim_top.sv ====
// packet mode interrupt mapping and packet-handler control gating
`timescale 1ns/100ps
`default_nettype none
module pmim_top
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [2:0]  chip_operating_mode,
	input  wire logic [1:0]  line_a_rx_source_sel,
	input  wire logic [1:0]  line_b_rx_source_sel,
	input  wire logic        line_a_tx_source_sel,
	input  wire logic        line_b_tx_source_sel,
	input  wire logic        packet_format_sel,
	input  wire logic [6:0]  payload_len_setting,
	input  wire logic [7:0]  node_addr_value,
	input  wire logic [1:0]  addr_filter_mode,
	input  wire logic [1:0]  preamble_len_sel,
	input  wire logic        sync_recog_en,
	input  wire logic [1:0]  sync_word_len,
	input  wire logic [1:0]  sync_error_tolerance,
	input  wire logic [31:0] sync_value,
	input  wire logic        autoclear_on_bad_check,
	input  wire logic        scrambler_en,
	input  wire logic        checksum_en,
	input  wire logic        biphase_coding_en,
	input  wire logic        last_byte_in_queue,
	input  wire logic        check_result_ok,
	input  wire logic        check_result_valid,
	input  wire logic        sync_seen,
	input  wire logic        addr_seen,
	input  wire logic        byte_written_evt,
	input  wire logic        queue_empty_evt,
	input  wire logic        queue_full_evt,
	input  wire logic        queue_level_evt,
	input  wire logic        rssi_evt,
	input  wire logic        send_complete_evt,
	input  wire logic        tx_ready,
	input  wire logic [6:0]  rx_len_byte,
	output logic             irq_line_a,
	output logic             irq_line_b,
	output logic             payload_ready_evt,
	output logic             check_pass_evt,
	output logic             addr_match_evt,
	output logic             tx_start,
	output logic             queue_flush,
	output logic             rx_len_accept,
	output logic             rx_len_fixed,
	output logic [6:0]       tx_len,
	output logic             tx_len_fixed,
	output logic [1:0]       tx_preamble_len,
	output logic             tx_scramble,
	output logic             tx_checksum,
	output logic             tx_biphase,
	output logic             rx_scramble,
	output logic             rx_checksum,
	output logic             rx_biphase,
	output logic             rx_sync_en,
	output logic [1:0]       rx_sync_len,
	output logic [1:0]       rx_sync_tol,
	output logic [31:0]      rx_sync_value,
	output logic [7:0]       rx_node_addr,
	output logic [1:0]       rx_addr_filter
);
	// ==========================================================
	// held receive events
	logic ready_r, ready_nxt;
	logic pass_r, pass_nxt;
	logic match_r, match_nxt;
	logic filt_on;
	logic in_rx, in_tx;

	assign in_rx = (chip_operating_mode == pmim_pkg::MODE_RX);
	assign in_tx = (chip_operating_mode == pmim_pkg::MODE_TX);
	assign filt_on = (addr_filter_mode != pmim_pkg::ADDR_FILT_OFF);

	always_comb
	begin
		ready_nxt = ready_r;
		pass_nxt  = pass_r;
		match_nxt = match_r;
		// drained queue clears; a new set wins over the clear
		if (queue_empty_evt)
		begin
			ready_nxt = 1'b0;
			pass_nxt  = 1'b0;
			match_nxt = 1'b0;
		end
		if (in_rx && last_byte_in_queue)
		begin
			// bad check with autoclear: no ready, queue flushed
			ready_nxt = ~(checksum_en & autoclear_on_bad_check & ~check_result_ok);
		end
		if (in_rx && check_result_valid && check_result_ok && checksum_en)
			pass_nxt = 1'b1;
		if (in_rx && (sync_seen || (addr_seen && filt_on)))
			match_nxt = 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ready_r <= pmim_pkg::FLAG_RST;
			pass_r  <= pmim_pkg::FLAG_RST;
			match_r <= pmim_pkg::FLAG_RST;
		end
		else
		begin
			ready_r <= ready_nxt;
			pass_r  <= pass_nxt;
			match_r <= match_nxt;
		end
	end

	// ==========================================================
	// interrupt line selection
	logic line_a_c, line_b_c;

	pmim_sel u_sel
	(
		.mode      (chip_operating_mode),
		.a_rx_sel  (line_a_rx_source_sel),
		.b_rx_sel  (line_b_rx_source_sel),
		.a_tx_sel  (line_a_tx_source_sel),
		.b_tx_sel  (line_b_tx_source_sel),
		.ready_ev  (ready_r),
		.wrbyte_ev (byte_written_evt),
		.empty_ev  (queue_empty_evt),
		.match_ev  (match_r),
		.full_ev   (queue_full_evt),
		.pass_ev   (pass_r),
		.rssi_ev   (rssi_evt),
		.level_ev  (queue_level_evt),
		.done_ev   (send_complete_evt),
		.line_a    (line_a_c),
		.line_b    (line_b_c)
	);

	// ==========================================================
	// interrupt line registers
	logic ia_r, ia_nxt;
	logic ib_r, ib_nxt;

	always_comb
	begin
		// levels follow the selected source one cycle later
		ia_nxt = line_a_c;
		ib_nxt = line_b_c;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ia_r <= pmim_pkg::IRQ_RST;
			ib_r <= pmim_pkg::IRQ_RST;
		end
		else
		begin
			ia_r <= ia_nxt;
			ib_r <= ib_nxt;
		end
	end

	// ==========================================================
	// packet start, flush and length acceptance
	logic start_r, start_nxt;
	logic flush_r, flush_nxt;
	logic acc_r, acc_nxt;
	logic bad_check;

	// failed check at the last byte with autoclear armed
	assign bad_check = in_rx & last_byte_in_queue & checksum_en
		& autoclear_on_bad_check & ~check_result_ok;

	always_comb
	begin
		start_nxt = in_tx & line_a_tx_source_sel & tx_ready & ~queue_empty_evt;
		flush_nxt = (in_tx & line_a_tx_source_sel & send_complete_evt)
			| bad_check;
		// variable format: length byte must not exceed the maximum
		acc_nxt = packet_format_sel | (rx_len_byte <= payload_len_setting);
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			start_r <= 1'b0;
			flush_r <= 1'b0;
			acc_r   <= 1'b0;
		end
		else
		begin
			start_r <= start_nxt;
			flush_r <= flush_nxt;
			acc_r   <= acc_nxt;
		end
	end

	// ==========================================================
	// transmit-side settings and the packet format shared with the receive side
	logic [6:0] tx_len_r, tx_len_nxt;
	logic       fmt_r, fmt_nxt;
	logic [1:0] pre_r, pre_nxt;
	logic [2:0] tx_cfg_r, tx_cfg_nxt;

	always_comb
	begin
		tx_len_nxt = payload_len_setting;
		fmt_nxt    = packet_format_sel;
		// preamble length only reaches the transmit side
		pre_nxt    = preamble_len_sel;
		tx_cfg_nxt = {scrambler_en, checksum_en, biphase_coding_en};
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_len_r <= 7'h00;
			fmt_r    <= 1'b0;
			pre_r    <= 2'h0;
			tx_cfg_r <= 3'h0;
		end
		else
		begin
			tx_len_r <= tx_len_nxt;
			fmt_r    <= fmt_nxt;
			pre_r    <= pre_nxt;
			tx_cfg_r <= tx_cfg_nxt;
		end
	end

	// ==========================================================
	// receive-side settings
	logic [2:0]  rx_cfg_r, rx_cfg_nxt;
	logic        sync_en_r, sync_en_nxt;
	logic [1:0]  sync_len_r, sync_len_nxt;
	logic [1:0]  sync_tol_r, sync_tol_nxt;
	logic [31:0] sync_val_r, sync_val_nxt;
	logic [7:0]  addr_r, addr_nxt;
	logic [1:0]  filt_r, filt_nxt;

	always_comb
	begin
		rx_cfg_nxt   = {scrambler_en, checksum_en, biphase_coding_en};
		sync_en_nxt  = sync_recog_en;
		sync_len_nxt = sync_word_len;
		sync_tol_nxt = sync_error_tolerance;
		sync_val_nxt = sync_value;
		// node address and filter mode never reach the transmit side
		addr_nxt     = node_addr_value;
		filt_nxt     = addr_filter_mode;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_cfg_r   <= 3'h0;
			sync_en_r  <= 1'b0;
			sync_len_r <= 2'h0;
			sync_tol_r <= 2'h0;
			sync_val_r <= 32'h0000_0000;
			addr_r     <= 8'h00;
			filt_r     <= 2'h0;
		end
		else
		begin
			rx_cfg_r   <= rx_cfg_nxt;
			sync_en_r  <= sync_en_nxt;
			sync_len_r <= sync_len_nxt;
			sync_tol_r <= sync_tol_nxt;
			sync_val_r <= sync_val_nxt;
			addr_r     <= addr_nxt;
			filt_r     <= filt_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign irq_line_a        = ia_r;
	assign irq_line_b        = ib_r;
	assign payload_ready_evt = ready_r;
	assign check_pass_evt    = pass_r;
	assign addr_match_evt    = match_r;
	assign tx_start          = start_r;
	assign queue_flush       = flush_r;
	assign rx_len_accept     = acc_r;
	assign rx_len_fixed      = fmt_r;
	assign tx_len            = tx_len_r;
	assign tx_len_fixed      = fmt_r;
	assign tx_preamble_len   = pre_r;
	assign tx_scramble       = tx_cfg_r[2];
	assign tx_checksum       = tx_cfg_r[1];
	assign tx_biphase        = tx_cfg_r[0];
	assign rx_scramble       = rx_cfg_r[2];
	assign rx_checksum       = rx_cfg_r[1];
	assign rx_biphase        = rx_cfg_r[0];
	assign rx_sync_en        = sync_en_r;
	assign rx_sync_len       = sync_len_r;
	assign rx_sync_tol       = sync_tol_r;
	assign rx_sync_value     = sync_val_r;
	assign rx_node_addr      = addr_r;
	assign rx_addr_filter    = filt_r;
endmodule // pmim_top
`default_nettype wire

// ==== tb_pmim_top.sv ====
// self-checking bench for the interrupt mapping block
`timescale 1ns/100ps
`default_nettype none
module tb_pmim_top;
	logic core_clk = 0, arst_n = 0, packet_format_sel = 0, sync_recog_en = 0, tx_ready = 0;
	logic autoclear_on_bad_check = 0, scrambler_en = 0, checksum_en = 0, biphase_coding_en = 0;
	logic last_byte_in_queue = 0, check_result_ok = 0, check_result_valid = 0, sync_seen = 0;
	logic addr_seen = 0, line_a_tx_source_sel = 0, line_b_tx_source_sel = 0;
	logic [1:0] line_a_rx_source_sel = 0, line_b_rx_source_sel = 0, addr_filter_mode = 0;
	logic [1:0] preamble_len_sel = 0, sync_word_len = 0, sync_error_tolerance = 0, seq_cmd = 0;
	logic [2:0] want_mode = 0;
	logic [5:0] lv = 0;
	logic [6:0] payload_len_setting = 0, rx_len_byte = 0, tx_len;
	logic [7:0] node_addr_value = 0, rx_node_addr;
	logic [31:0] sync_value = 0, rx_sync_value;
	wire logic [2:0] chip_operating_mode;
	wire logic byte_written_evt = lv[0], queue_empty_evt = lv[1], queue_full_evt = lv[2];
	wire logic queue_level_evt = lv[3], rssi_evt = lv[4], send_complete_evt = lv[5];
	logic irq_line_a, irq_line_b, payload_ready_evt, check_pass_evt, addr_match_evt, tx_start;
	logic queue_flush, rx_len_accept, rx_len_fixed, tx_len_fixed, tx_scramble, tx_checksum;
	logic tx_biphase, rx_scramble, rx_checksum, rx_biphase, rx_sync_en, rd_strobe, busy;
	logic [1:0] tx_preamble_len, rx_sync_len, rx_sync_tol, rx_addr_filter;
	int bad_count = 0, check_count = 0, reads = 0;
	// ========
	// block, host model, clock and helpers
	pmim_top dut_u (.*);
	pmim_host #(.BIT_CYC(4)) host_u (.core_clk, .want_mode, .seq_cmd, .irq_line_a,
		.irq_line_b, .mode(chip_operating_mode), .rd_strobe, .busy);
	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk) if (rd_strobe) reads++;
	task tk(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task pulse(input logic ok);
		{last_byte_in_queue, check_result_valid, check_result_ok} = {2'h3, ok};
		tk(1);
		{last_byte_in_queue, check_result_valid} = 2'h0;
	endtask
	// expected {line b, line a} with held flags clear; lv bits: wr, empty, full, level, rssi, done
	function automatic logic [1:0] exp_ab(input logic [2:0] m, input logic [1:0] s, logic [5:0] v);
		case (m)
			pmim_pkg::MODE_RX: exp_ab = {s == 1 ? v[2] : s == 2 ? v[4] : s == 3 && v[3],
				s == 1 ? v[0] : s == 2 && v[1]};
			pmim_pkg::MODE_STANDBY: exp_ab = {(s == 1 && v[2]) || (s == 3 && v[3]), s == 2 && v[1]};
			pmim_pkg::MODE_TX: exp_ab = {s[1] ? v[5] : v[2], s[0] ? v[1] : v[3]};
			default: exp_ab = 2'h0;
		endcase
	endfunction
	// ========
	// scenarios
	task t_map;
		for (int m = 0; m < 5; m++)
			for (int s = 0; s < 4; s++)
				for (int p = 0; p < 7; p++)
				begin
					want_mode = m[2:0];
					{line_a_rx_source_sel, line_b_rx_source_sel} = {2{s[1:0]}};
					{line_b_tx_source_sel, line_a_tx_source_sel} = s[1:0];
					lv = p == 0 ? 6'h0 : 6'h1 << (p - 1);
					tk(2);
					chk({irq_line_b, irq_line_a}, exp_ab(m[2:0], s[1:0], lv));
				end
		lv = 0;
		$display("map done");
	endtask
	task t_held;
		want_mode = pmim_pkg::MODE_RX;
		{line_a_rx_source_sel, line_b_rx_source_sel} = 4'h0;
		checksum_en = 1;
		addr_seen = 1;
		pulse(1);
		addr_seen = 0;
		tk(6);
		chk({irq_line_b, irq_line_a, check_pass_evt, payload_ready_evt, addr_match_evt}, 5'h1e);
		addr_filter_mode = 2'h1;
		addr_seen = 1;
		tk(1);
		addr_seen = 0;
		tk(1);
		chk(addr_match_evt, 1);
		lv = 6'h2;
		tk(1);
		lv = 0;
		tk(2);
		chk({irq_line_a, payload_ready_evt, check_pass_evt, addr_match_evt}, 0);
		addr_filter_mode = 2'h0;
		line_a_rx_source_sel = 2'h3;
		sync_seen = 1;
		tk(1);
		sync_seen = 0;
		tk(2);
		chk({irq_line_a, addr_match_evt}, 2'h3);
		lv = 6'h2;
		tk(1);
		lv = 0;
		tk(2);
		chk({irq_line_a, addr_match_evt}, 2'h0);
		$display("held done");
	endtask
	task t_bad;
		for (int c = 1; c >= 0; c--)
		begin
			autoclear_on_bad_check = c[0];
			pulse(0);
			chk(queue_flush, c[0]);
			tk(2);
			chk(payload_ready_evt, !c[0]);
			lv = 6'h2;
			tk(2);
			lv = 0;
		end
		$display("bad check done");
	endtask
	task t_tx;
		want_mode = pmim_pkg::MODE_SLEEP;
		{line_a_tx_source_sel, line_b_tx_source_sel, tx_ready, seq_cmd} = 5'h1d;
		tk(1);
		seq_cmd = 0;
		for (int i = 0; i < 20 && tx_start !== 1'b1; i++) tk(1);
		chk(tx_start, 1);
		lv = 6'h20;
		tk(2);
		chk(queue_flush, 1);
		lv = 0;
		for (int i = 0; i < 20 && busy; i++) tk(1);
		tk(1);
		chk({busy, chip_operating_mode, tx_start}, 0);
		{want_mode, line_a_tx_source_sel, lv} = {pmim_pkg::MODE_TX, 1'b0, 6'h20};
		tk(2);
		chk({queue_flush, tx_start}, 0);
		{want_mode, lv} = 0;
		$display("tx done");
	endtask
	task t_rx;
		{line_a_rx_source_sel, line_b_rx_source_sel, seq_cmd} = {4'h8, 2'h2};
		reads = 0;
		tk(3);
		seq_cmd = 0;
		pulse(1);
		for (int i = 0; i < 30 && reads < 3; i++) tk(1);
		lv = 6'h2;
		for (int i = 0; i < 30 && busy; i++) tk(1);
		chk({busy, chip_operating_mode, payload_ready_evt}, 0);
		chk(reads > 2, 1);
		lv = 0;
		$display("rx done");
	endtask
	task t_cfg;
		for (int k = 0; k < 3; k++)
		begin
			{packet_format_sel, payload_len_setting} = {k == 2, 7'h40};
			rx_len_byte = k == 1 ? 7'h40 : 7'h41;
			{sync_recog_en, scrambler_en, checksum_en, biphase_coding_en} = {4{k[0]}};
			{preamble_len_sel, sync_word_len, sync_error_tolerance, addr_filter_mode} = {4{k[1:0]}};
			{node_addr_value, sync_value} = {8'h5a + 8'(k), 32'h1234_5678 << k};
			tk(2);
			chk({rx_len_accept, rx_len_fixed, tx_len_fixed, tx_len}, {k != 0, {2{k == 2}}, 7'h40});
			chk({rx_node_addr, rx_addr_filter}, {node_addr_value, k[1:0]});
			chk(tx_preamble_len, k[1:0]);
			chk({rx_sync_en, rx_sync_len, rx_sync_tol, rx_sync_value}, {k[0], {2{k[1:0]}}, sync_value});
			chk({tx_scramble, rx_scramble, tx_checksum, rx_checksum, tx_biphase, rx_biphase}, {6{k[0]}});
		end
		$display("cfg done");
	endtask
	initial
	begin
		tk(5);
		arst_n = 1;
		tk(1);
		t_map;
		t_held;
		t_bad;
		t_tx;
		t_rx;
		t_cfg;
		complete_run;
	end
	initial
	begin
		#50us;
		bad_count++;
		complete_run;
	end
endmodule // tb_pmim_top
`default_nettype wire
